// [inc/safety_monitor_pkg.sv]
// Package of types and constants for the dual-channel safety input monitor.
package safety_monitor_pkg;

  // Input configuration selection.
  typedef enum logic [2:0]
  {
    cfg_single   = 3'h0,
    cfg_dual_no  = 3'h1,
    cfg_no_nc    = 3'h2,
    cfg_zero_24v = 3'h3,
    cfg_mat      = 3'h4
  } input_cfg_t;

  // Raw field-side inputs, all active high meaning contact closed.
  typedef struct packed
  {
    logic ch_a;
    logic ch_b;
    logic shorted;
    logic reset_btn;
    logic test_ok;
  } field_in_t;

  // Register offsets of the software port.
  localparam logic [3:0] reg_ctrl_addr   = 4'h0;
  localparam logic [3:0] reg_status_addr = 4'h1;
  localparam logic [3:0] reg_irq_addr    = 4'h2;
  localparam logic [3:0] reg_mask_addr   = 4'h3;

  // Control register fields.
  localparam int ctrl_cfg_lsb  = 0;
  localparam int ctrl_auto_bit = 3;
  localparam logic [7:0] ctrl_reset_val = 8'h00;

  // Interrupt event bits.
  localparam int irq_w        = 3;
  localparam int irq_stop_bit = 0;
  localparam int irq_run_bit  = 1;
  localparam int irq_rej_bit  = 2;

  // Reset button held longer than this is treated as stuck (1 s at 20 MHz).
  localparam int clk_hz         = 20_000_000;
  localparam int stuck_ms       = 1000;
  localparam int stuck_cycles   = clk_hz / 1000 * stuck_ms;

endpackage

// [rtl/safety_input_monitor.sv]
// Sequencing logic of a dual-channel safety relay input monitor.
module safety_input_monitor
  #(
    parameter int stuck_limit = safety_monitor_pkg::stuck_cycles
  )
  (
    // Clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          resetn,
    // Field inputs
    input  wire safety_monitor_pkg::field_in_t field_in,
    // Software port
    input  wire logic [3:0]                    reg_addr,
    input  wire logic [7:0]                    reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic [7:0]                         reg_rdata,
    // Outputs
    output logic                               outputs_on,
    output logic                               irq
  );
  import safety_monitor_pkg::*;

  typedef enum logic [1:0]
  {
    st_wait_release,
    st_ready,
    st_run
  } state_t;

  field_in_t    meta_q;
  field_in_t    sync_q;
  logic [7:0]   ctrl_q;
  logic [irq_w-1:0] irq_q;
  logic [irq_w-1:0] mask_q;
  state_t       state_q;
  logic         btn_prev_q;
  logic         btn_armed_q;
  logic         btn_stuck_q;
  logic [31:0]  btn_cnt_q;
  input_cfg_t   cfg;
  logic         auto_mode;
  logic         inputs_ok;
  logic         inputs_idle;
  logic         reset_ok;
  logic         go;
  logic         stop;
  logic [irq_w-1:0] ev;
  logic         idle_seen_q;

  assign cfg       = input_cfg_t'(ctrl_q[ctrl_cfg_lsb +: 3]);
  assign auto_mode = ctrl_q[ctrl_auto_bit];

  // Two-stage synchroniser; only the second stage is used by the logic.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= field_in;
      sync_q <= meta_q;
    end
  end

  // Run conditions and idle positions per configuration.
  always_comb
  begin
    inputs_ok   = 1'b0;
    inputs_idle = 1'b0;
    unique case (cfg)
      cfg_single:
      begin
        inputs_ok   = sync_q.ch_a;
        inputs_idle = !sync_q.ch_a;
      end
      cfg_dual_no:
      begin
        // A short cannot be seen with both contacts from the same supply.
        inputs_ok   = sync_q.ch_a && sync_q.ch_b;
        inputs_idle = !sync_q.ch_a && !sync_q.ch_b;
      end
      cfg_no_nc:
      begin
        inputs_ok   = sync_q.ch_a && !sync_q.ch_b && !sync_q.shorted;
        inputs_idle = !sync_q.ch_a && sync_q.ch_b && !sync_q.shorted;
      end
      cfg_zero_24v:
      begin
        inputs_ok   = sync_q.ch_a && sync_q.ch_b && !sync_q.shorted;
        inputs_idle = !sync_q.ch_a && !sync_q.ch_b;
      end
      cfg_mat:
      begin
        inputs_ok   = sync_q.ch_a && sync_q.ch_b && !sync_q.shorted;
        inputs_idle = 1'b1;
      end
      default:
      begin
        inputs_ok   = 1'b0;
        inputs_idle = 1'b0;
      end
    endcase
  end

  // Monitored reset: arm on press, accept on release, refuse if held too long.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      btn_prev_q  <= 1'b0;
      btn_armed_q <= 1'b0;
      btn_stuck_q <= 1'b0;
      btn_cnt_q   <= '0;
    end
    else
    begin
      btn_prev_q <= sync_q.reset_btn;
      if (sync_q.reset_btn)
      begin
        if (btn_cnt_q < 32'(stuck_limit))
          btn_cnt_q <= btn_cnt_q + 32'h1;
        else
          btn_stuck_q <= 1'b1;
        // A press only counts if it starts from a released button.
        if (!btn_prev_q)
          btn_armed_q <= 1'b1;
      end
      else
      begin
        btn_cnt_q <= '0;
        if (btn_prev_q)
          btn_armed_q <= 1'b0;
        if (btn_prev_q)
          btn_stuck_q <= 1'b0;
      end
    end
  end

  assign reset_ok = auto_mode ? 1'b1
                  : (btn_prev_q && !sync_q.reset_btn && btn_armed_q && !btn_stuck_q);
  assign go   = inputs_ok && sync_q.test_ok && reset_ok;
  assign stop = !inputs_ok;

  // Sequencer.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      state_q <= st_wait_release;
    else
    begin
      unique case (state_q)
        st_wait_release:
          if (inputs_idle)
            state_q <= st_ready;
        st_ready:
          if (go)
            state_q <= st_run;
        st_run:
          if (stop)
            state_q <= st_wait_release;
        default:
          state_q <= st_wait_release;
      endcase
    end
  end

  assign outputs_on = (state_q == st_run);

  // Events: stop, start, and a refused manual reset.
  assign ev[irq_stop_bit] = (state_q == st_run) && stop;
  assign ev[irq_run_bit]  = (state_q == st_ready) && go;
  assign ev[irq_rej_bit]  = !auto_mode && btn_prev_q && !sync_q.reset_btn
                            && (btn_stuck_q || !btn_armed_q || !inputs_ok);

  // Registers; a set in the clearing cycle wins over the clear.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_q <= ctrl_reset_val;
      mask_q <= '0;
      irq_q  <= '0;
    end
    else
    begin
      if (reg_wr && reg_addr == reg_ctrl_addr)
        ctrl_q <= reg_wdata;
      if (reg_wr && reg_addr == reg_mask_addr)
        mask_q <= reg_wdata[irq_w-1:0];
      if (reg_wr && reg_addr == reg_irq_addr)
        irq_q <= (irq_q & ~reg_wdata[irq_w-1:0]) | ev;
      else
        irq_q <= irq_q | ev;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= '0;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        reg_ctrl_addr:   reg_rdata <= ctrl_q;
        reg_status_addr: reg_rdata <= {3'h0, btn_stuck_q, inputs_ok, 1'b0, state_q};
        reg_irq_addr:    reg_rdata <= {5'h00, irq_q};
        reg_mask_addr:   reg_rdata <= {5'h00, mask_q};
        default:         reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= '0;
  end

  assign irq = |(irq_q & mask_q);

  // Set once the idle positions are seen with the outputs off, so that the restart
  // assertion does not merely repeat the sequencer's own state decode.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      idle_seen_q <= 1'b0;
    else if (outputs_on)
      idle_seen_q <= 1'b0;
    else if (inputs_idle)
      idle_seen_q <= 1'b1;
  end

  // A stop shows three cycles after a pin opens, two of them spent in the synchroniser.
  a_stop_on_open: assert property (@(posedge ref_clk) disable iff (!resetn)
    (outputs_on && !inputs_ok) |=> !outputs_on)
    else $error("outputs stayed on after an input opened");
  a_no_run_bad: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(outputs_on) |-> $past(inputs_ok) && $past(sync_q.test_ok))
    else $error("outputs rose without valid inputs and test");
  a_restart_idle: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(outputs_on) |-> $past(idle_seen_q))
    else $error("outputs restarted without seeing inputs idle");
  a_short_stops: assert property (@(posedge ref_clk) disable iff (!resetn)
    (cfg == cfg_zero_24v && sync_q.shorted) |=> !outputs_on)
    else $error("short did not stop outputs");
  a_mat_stops: assert property (@(posedge ref_clk) disable iff (!resetn)
    (cfg == cfg_mat && !(sync_q.ch_a && sync_q.ch_b)) |=> !outputs_on)
    else $error("mat actuation did not stop outputs");
  a_manual_edge: assert property (@(posedge ref_clk) disable iff (!resetn)
    ($rose(outputs_on) && !$past(auto_mode)) |-> $past(btn_prev_q) && !$past(sync_q.reset_btn))
    else $error("manual reset accepted without release");
  a_stuck_refuse: assert property (@(posedge ref_clk) disable iff (!resetn)
    (btn_stuck_q && !auto_mode && !outputs_on) |=> !outputs_on)
    else $error("stuck reset button was accepted");
  a_auto_go: assert property (@(posedge ref_clk) disable iff (!resetn)
    (auto_mode && state_q == st_ready && inputs_ok && sync_q.test_ok) |=> outputs_on)
    else $error("automatic reset did not energise");
  a_nonc_pos: assert property (@(posedge ref_clk) disable iff (!resetn)
    (cfg == cfg_no_nc && outputs_on) |-> $past(sync_q.ch_a) && !$past(sync_q.ch_b))
    else $error("no-nc mode ran with wrong positions");
  a_dual_both: assert property (@(posedge ref_clk) disable iff (!resetn)
    (cfg == cfg_dual_no && !(sync_q.ch_a && sync_q.ch_b)) |=> !outputs_on)
    else $error("dual mode ran without both channels closed");
  a_mat_allow: assert property (@(posedge ref_clk) disable iff (!resetn)
    (cfg == cfg_mat && outputs_on) |-> $past(sync_q.ch_a && sync_q.ch_b))
    else $error("mat mode ran without both channels made");
  a_stop_event: assert property (@(posedge ref_clk) disable iff (!resetn)
    $fell(outputs_on) |-> irq_q[irq_stop_bit])
    else $error("stop did not set its status bit");
  a_reject_event: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!auto_mode && btn_stuck_q && btn_prev_q && !sync_q.reset_btn) |=> irq_q[irq_rej_bit])
    else $error("refused reset did not set its status bit");
  a_held_button: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!auto_mode && sync_q.reset_btn) |=> !$rose(outputs_on))
    else $error("held reset button started the outputs");
  a_test_blocks: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!sync_q.test_ok && !outputs_on) |=> !outputs_on)
    else $error("outputs started with the test input open");

  c_auto_run: cover property (@(posedge ref_clk) disable iff (!resetn)
    auto_mode && $rose(outputs_on));
  c_manual_run: cover property (@(posedge ref_clk) disable iff (!resetn)
    !auto_mode && $rose(outputs_on));
  c_stop: cover property (@(posedge ref_clk) disable iff (!resetn)
    $fell(outputs_on));
  c_irq: cover property (@(posedge ref_clk) disable iff (!resetn)
    $rose(irq));
  c_refused: cover property (@(posedge ref_clk) disable iff (!resetn)
    $rose(irq_q[irq_rej_bit]));

endmodule

// [dv/field_model.sv]
// Model of the field side: safety contacts, reset button and monitored contactors.
module field_model
  #(
    parameter int drop_cycles = 4
  )
  (
    // Clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          resetn,
    // Stimulus from the bench
    input  wire safety_monitor_pkg::field_in_t contacts,
    input  wire logic                          weld,
    // Relay side
    input  wire logic                          outputs_on,
    output safety_monitor_pkg::field_in_t      field_in
  );
  import safety_monitor_pkg::*;
  int unsigned drop_q;
  // Contactors drop out late, so a restart right after a stop still sees them pulled in.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      drop_q <= 0;
    else if (outputs_on)
      drop_q <= drop_cycles;
    else if (drop_q != 0)
      drop_q <= drop_q - 1;
  end
  always_comb
  begin
    field_in = contacts;
    field_in.test_ok = !weld && !outputs_on && drop_q == 0;
  end
endmodule

// [dv/testbench.sv]
// Self-checking testbench for the safety input monitor.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import safety_monitor_pkg::*;
  localparam int stuck_lim = 20;
  logic       ref_clk;
  logic       resetn;
  field_in_t  sw;
  logic       weld;
  field_in_t  field_in;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       outputs_on;
  logic       irq;
  logic       rd_q;
  logic       on_q;
  logic       exp_on;
  logic [8:0] q_rd[$];
  logic       q_on[$];
  int         n_fail;
  int         check_count;

  safety_input_monitor #(.stuck_limit(stuck_lim)) dut
  (
    .ref_clk(ref_clk), .resetn(resetn), .field_in(field_in), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .outputs_on(outputs_on), .irq(irq)
  );
  field_model fm
  (
    .ref_clk(ref_clk), .resetn(resetn), .contacts(sw), .weld(weld),
    .outputs_on(outputs_on), .field_in(field_in)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic print_verdict();
    if (q_on.size() + q_rd.size() != 0)
      n_fail++;
    if (n_fail == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic cmp_on(input logic got);
    logic e;
    e = (q_on.size() != 0) ? q_on.pop_front() : 1'bx;
    check_count++;
    if (got !== e)
    begin
      n_fail++;
      $display("Error at %0t: outputs_on %b, expected %b", $time, got, e);
    end
  endtask

  task automatic cmp_rd(input logic [8:0] got);
    logic [8:0] e;
    e = (q_rd.size() != 0) ? q_rd.pop_front() : {9{1'bx}};
    check_count++;
    if (got !== e)
    begin
      n_fail++;
      $display("Error at %0t: irq and read data %h, expected %h", $time, got, e);
    end
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken one edge later.
  always @(posedge ref_clk)
  begin
    if (rd_q)
      cmp_rd({irq, reg_rdata});
    // The unknown state before the first reset edge is not compared; a mid-run reset is.
    if ((resetn === 1'b1 || on_q === 1'b1) && outputs_on !== on_q)
      cmp_on(outputs_on);
    rd_q <= reg_rd;
    on_q <= outputs_on;
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [8:0] e);
    q_rd.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic step(input logic [4:0] s, input logic v);
    sw <= s;
    if (v !== exp_on)
      q_on.push_back(v);
    exp_on = v;
    repeat (14 + $urandom % 4) @(posedge ref_clk);
  endtask

  task automatic mode(input input_cfg_t c, input logic au);
    step(5'h00, 1'b0);
    wr(reg_ctrl_addr, {4'h0, au, c});
  endtask

  initial
  begin
    repeat (8000) @(posedge ref_clk);
    n_fail++;
    print_verdict();
  end

  initial
  begin
    resetn = 1'b0;
    sw = 5'h00;
    weld = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rd_q = 1'b0;
    on_q = 1'b0;
    exp_on = 1'b0;
    n_fail = 0;
    check_count = 0;
    void'($urandom(8));
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    rd(reg_ctrl_addr, {1'b0, ctrl_reset_val});
    wr(4'hf, 8'($urandom));
    rd(4'hf, 9'h000);
    mode(cfg_dual_no, 1'b1);
    step(5'h10, 1'b0);
    step(5'h18, 1'b1);
    step(5'h10, 1'b0);
    step(5'h18, 1'b0);
    step(5'h00, 1'b0);
    step(5'h18, 1'b1);
    step(5'h1c, 1'b1);
    step(5'h00, 1'b0);
    weld <= 1'b1;
    step(5'h18, 1'b0);
    weld <= 1'b0;
    step(5'h18, 1'b1);
    mode(cfg_zero_24v, 1'b1);
    step(5'h18, 1'b1);
    step(5'h1c, 1'b0);
    mode(cfg_mat, 1'b1);
    step(5'h18, 1'b1);
    step(5'h08, 1'b0);
    step(5'h18, 1'b1);
    step(5'h1c, 1'b0);
    mode(cfg_no_nc, 1'b1);
    step(5'h08, 1'b0);
    step(5'h10, 1'b1);
    step(5'h18, 1'b0);
    step(5'h10, 1'b0);
    step(5'h08, 1'b0);
    step(5'h10, 1'b1);
    mode(cfg_single, 1'b1);
    step(5'h10, 1'b1);
    mode(cfg_dual_no, 1'b0);
    wr(reg_mask_addr, 8'h07);
    step(5'h18, 1'b0);
    step(5'h1a, 1'b0);
    step(5'h18, 1'b1);
    rd(reg_status_addr, {1'b1, 8'h0a});
    step(5'h00, 1'b0);
    step(5'h18, 1'b0);
    step(5'h1a, 1'b0);
    step(5'h1a, 1'b0);
    rd(reg_status_addr, {1'b1, 8'h19});
    step(5'h18, 1'b0);
    step(5'h02, 1'b0);
    step(5'h00, 1'b0);
    rd(reg_irq_addr, {1'b1, 8'h07});
    wr(reg_mask_addr, 8'h00);
    rd(reg_irq_addr, {1'b0, 8'h07});
    wr(reg_mask_addr, 8'h07);
    wr(reg_irq_addr, 8'h07);
    rd(reg_irq_addr, {1'b0, 8'h00});
    mode(cfg_dual_no, 1'b1);
    step(5'h18, 1'b1);
    resetn <= 1'b0;
    q_on.push_back(1'b0);
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (8) @(posedge ref_clk);
    print_verdict();
  end
endmodule
